// [include/vfd_regs.vh]
`ifndef VFD_REGS_VH
`define VFD_REGS_VH

// byte addresses of the divider configuration registers
`define VFD_ADDR_FB_HI      8'h00
`define VFD_ADDR_FB_LO      8'h01
`define VFD_ADDR_MON_LO     8'h02
`define VFD_ADDR_MON_HI     8'h03
`define VFD_ADDR_REF_HI     8'h04
`define VFD_ADDR_REF_LO     8'h05

// field positions inside the high bytes
`define VFD_PHASE_MSB       7
`define VFD_PHASE_LSB       5
`define VFD_PD_BIT          4
`define VFD_DIV12_HI_MSB    3
`define VFD_MON_BIT8        7

// reset values
`define VFD_RST_FB_DIV      12'hc00
`define VFD_RST_FB_PHASE    3'h5
`define VFD_RST_MON_DIV     9'h01e
`define VFD_RST_MON_PD      1'h0
`define VFD_RST_REF_DIV     12'hc00
`define VFD_RST_REF_PHASE   3'h5

// widths
`define VFD_MAIN_W          12
`define VFD_MON_W           9
`define VFD_PHASE_W         3

`endif

// [rtl/vfd_divider.v]
`timescale 1ns/10ps
// programmable integer divider on a tick enable, one-cycle output pulse
module vfd_divider #(
    parameter WIDTH = 12
) (
    input  wire             clk_i,     // system clock
    input  wire             rst_i,     // async reset, high
    input  wire             tick_i,    // input rate tick
    input  wire [WIDTH-1:0] div_i,     // division ratio
    input  wire             restart_i, // new ratio applied
    input  wire             pd_i,      // power down
    output reg              pulse_o    // divided tick
);

    reg  [WIDTH-1:0] cnt_r;
    reg  [WIDTH-1:0] cnt_nxt;
    reg              pulse_nxt;
    wire             last;

    // ratio 0 or 1 behaves as divide by one
    assign last = (cnt_r >= div_i) || (div_i <= {{(WIDTH-1){1'b0}}, 1'b1});

    // count input ticks, pulse on the last one of each period
    always @*
    begin
        cnt_nxt   = cnt_r;
        pulse_nxt = 1'b0;
        if (pd_i || restart_i)
        begin
            cnt_nxt = {{(WIDTH-1){1'b0}}, 1'b1};
        end
        else if (tick_i)
        begin
            if (last)
            begin
                cnt_nxt   = {{(WIDTH-1){1'b0}}, 1'b1};
                pulse_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // state registers
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r   <= {{(WIDTH-1){1'b0}}, 1'b1};
            pulse_o <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            pulse_o <= pulse_nxt;
        end
    end

endmodule // vfd_divider

// [rtl/vfd_top.v]
// Behaviour
// - feedback path divided by 12-bit main divider, 1..4095, reset 3072
// - monitor path divided by 9-bit monitor divider, 4..511, reset 30
// - monitor powerdown bit 1 stops monitor divider; reset 0 runs it
// - lock window formed from reference and feedback phase, after detector edge
// - reference divided by 12-bit pre-divider, 1..4095, reset 3072
`timescale 1ns/10ps
`include "vfd_regs.vh"
module vfd_top #(
    parameter MAIN_W  = `VFD_MAIN_W,
    parameter MON_W   = `VFD_MON_W,
    parameter PHASE_W = `VFD_PHASE_W
) (
    input  wire               CLOCK_I,       // 40 MHz clock
    input  wire               RST_I,         // async reset, high
    input  wire [7:0]         REG_ADDR_I,    // register byte address
    input  wire [7:0]         REG_WDATA_I,   // write byte
    input  wire               REG_WR_I,      // write strobe
    input  wire               REG_RD_I,      // read strobe
    output reg  [7:0]         REG_RDATA_O,   // read byte
    input  wire               FB_TICK_I,     // feedback path tick
    input  wire               MON_TICK_I,    // monitor path tick
    input  wire               REF_TICK_I,    // reference tick
    output wire               FB_PULSE_O,    // divided feedback
    output wire               MON_PULSE_O,   // divided monitor path
    output wire               REF_PULSE_O,   // divided reference
    output reg                LD_SAMPLE_O,   // lock-detect sample strobe
    output reg  [2*PHASE_W-1:0] LD_WINDOW_O, // combined phase window
    output reg                MON_PD_O       // monitor divider powered down
);

    // applied settings
    reg  [MAIN_W-1:0]  main_feedback_divider_r;
    reg  [PHASE_W-1:0] feedback_phase_window_r;
    reg  [MON_W-1:0]   monitor_feedback_divider_r;
    reg                monitor_divider_powerdown_r;
    reg  [MAIN_W-1:0]  reference_pre_divider_r;
    reg  [PHASE_W-1:0] reference_phase_window_r;
    // staged high bytes / low byte
    reg  [7:0]         fb_hi_stage_r;
    reg  [7:0]         mon_lo_stage_r;
    reg  [7:0]         ref_hi_stage_r;
    // restart pulses on commit
    reg                fb_apply_r;
    reg                mon_apply_r;
    reg                ref_apply_r;
    // sample delay counter
    reg  [PHASE_W:0]   ld_cnt_r;
    reg                ld_run_r;
    reg  [7:0]         rdata_nxt;
    wire [PHASE_W:0]   ld_delay;

    // feedback path divider
    vfd_divider #(.WIDTH(MAIN_W)) u_fb_div (
        .clk_i     (CLOCK_I),
        .rst_i     (RST_I),
        .tick_i    (FB_TICK_I),
        .div_i     (main_feedback_divider_r),
        .restart_i (fb_apply_r),
        .pd_i      (1'b0),
        .pulse_o   (FB_PULSE_O)
    );

    // monitor path divider, stopped while powered down
    vfd_divider #(.WIDTH(MON_W)) u_mon_div (
        .clk_i     (CLOCK_I),
        .rst_i     (RST_I),
        .tick_i    (MON_TICK_I),
        .div_i     (monitor_feedback_divider_r),
        .restart_i (mon_apply_r),
        .pd_i      (monitor_divider_powerdown_r),
        .pulse_o   (MON_PULSE_O)
    );

    // reference pre-divider
    vfd_divider #(.WIDTH(MAIN_W)) u_ref_div (
        .clk_i     (CLOCK_I),
        .rst_i     (RST_I),
        .tick_i    (REF_TICK_I),
        .div_i     (reference_pre_divider_r),
        .restart_i (ref_apply_r),
        .pd_i      (1'b0),
        .pulse_o   (REF_PULSE_O)
    );

    // register writes: first byte of each divider field staged, field applied on its last byte; powerdown bit applied at once
    always @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            main_feedback_divider_r     <= `VFD_RST_FB_DIV;
            feedback_phase_window_r     <= `VFD_RST_FB_PHASE;
            monitor_feedback_divider_r  <= `VFD_RST_MON_DIV;
            monitor_divider_powerdown_r <= `VFD_RST_MON_PD;
            reference_pre_divider_r     <= `VFD_RST_REF_DIV;
            reference_phase_window_r    <= `VFD_RST_REF_PHASE;
            fb_hi_stage_r  <= {`VFD_RST_FB_PHASE, `VFD_RST_MON_PD, 4'hc};
            mon_lo_stage_r <= 8'h1e;
            ref_hi_stage_r <= {`VFD_RST_REF_PHASE, 1'b0, 4'hc};
            fb_apply_r     <= 1'b0;
            mon_apply_r    <= 1'b0;
            ref_apply_r    <= 1'b0;
        end
        else
        begin
            fb_apply_r  <= 1'b0;
            mon_apply_r <= 1'b0;
            ref_apply_r <= 1'b0;
            if (REG_WR_I)
            begin
                case (REG_ADDR_I)
                    `VFD_ADDR_FB_HI:
                    begin
                        fb_hi_stage_r <= REG_WDATA_I;
                        // powerdown is a single bit, applied at once
                        monitor_divider_powerdown_r <= REG_WDATA_I[`VFD_PD_BIT];
                    end
                    `VFD_ADDR_FB_LO:
                    begin
                        main_feedback_divider_r <= {fb_hi_stage_r[`VFD_DIV12_HI_MSB:0],
                                                    REG_WDATA_I};
                        feedback_phase_window_r <=
                            fb_hi_stage_r[`VFD_PHASE_MSB:`VFD_PHASE_LSB];
                        fb_apply_r <= 1'b1;
                    end
                    `VFD_ADDR_MON_LO:
                    begin
                        mon_lo_stage_r <= REG_WDATA_I;
                    end
                    `VFD_ADDR_MON_HI:
                    begin
                        monitor_feedback_divider_r <= {REG_WDATA_I[`VFD_MON_BIT8],
                                                       mon_lo_stage_r};
                        mon_apply_r <= 1'b1;
                    end
                    `VFD_ADDR_REF_HI:
                    begin
                        ref_hi_stage_r <= REG_WDATA_I;
                    end
                    `VFD_ADDR_REF_LO:
                    begin
                        reference_pre_divider_r <= {ref_hi_stage_r[`VFD_DIV12_HI_MSB:0],
                                                    REG_WDATA_I};
                        reference_phase_window_r <=
                            ref_hi_stage_r[`VFD_PHASE_MSB:`VFD_PHASE_LSB];
                        ref_apply_r <= 1'b1;
                    end
                    default:
                    begin
                        fb_apply_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // read mux over applied settings, unmapped and reserved bits read zero
    always @*
    begin
        rdata_nxt = 8'h00;
        case (REG_ADDR_I)
            `VFD_ADDR_FB_HI:  rdata_nxt = {feedback_phase_window_r,
                                           monitor_divider_powerdown_r,
                                           main_feedback_divider_r[11:8]};
            `VFD_ADDR_FB_LO:  rdata_nxt = main_feedback_divider_r[7:0];
            `VFD_ADDR_MON_LO: rdata_nxt = monitor_feedback_divider_r[7:0];
            `VFD_ADDR_MON_HI: rdata_nxt = {monitor_feedback_divider_r[8], 7'h00};
            `VFD_ADDR_REF_HI: rdata_nxt = {reference_phase_window_r, 1'b0,
                                           reference_pre_divider_r[11:8]};
            `VFD_ADDR_REF_LO: rdata_nxt = reference_pre_divider_r[7:0];
            default:          rdata_nxt = 8'h00;
        endcase
    end

    // sample delay after the detector edge: sum of both phase codes
    assign ld_delay = {1'b0, reference_phase_window_r}
                    + {1'b0, feedback_phase_window_r};

    // read data, status and lock-detect sampling
    always @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            REG_RDATA_O <= 8'h00;
            MON_PD_O    <= 1'b0;
            LD_WINDOW_O <= {2*PHASE_W{1'b0}};
            LD_SAMPLE_O <= 1'b0;
            ld_cnt_r    <= {(PHASE_W+1){1'b0}};
            ld_run_r    <= 1'b0;
        end
        else
        begin
            if (REG_RD_I)
            begin
                REG_RDATA_O <= rdata_nxt;
            end
            MON_PD_O    <= monitor_divider_powerdown_r;
            LD_WINDOW_O <= {reference_phase_window_r, feedback_phase_window_r};
            LD_SAMPLE_O <= 1'b0;
            // detector edge is the divided reference pulse
            if (REF_PULSE_O)
            begin
                ld_cnt_r <= {(PHASE_W+1){1'b0}};
                ld_run_r <= 1'b1;
            end
            else if (ld_run_r)
            begin
                if (ld_cnt_r >= ld_delay)
                begin
                    LD_SAMPLE_O <= 1'b1;
                    ld_run_r    <= 1'b0;
                end
                else
                begin
                    ld_cnt_r <= ld_cnt_r + {{PHASE_W{1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // vfd_top

// [sim/vfd_top_assertions.sv]
`timescale 1ns/10ps
module vfd_top_assertions (
    input wire       CLOCK_I,     // clock
    input wire       RST_I,       // async reset
    input wire [7:0] REG_ADDR_I,  // address
    input wire [7:0] REG_WDATA_I, // write byte
    input wire       REG_WR_I,    // write strobe
    input wire       FB_TICK_I,   // fb tick
    input wire       MON_TICK_I,  // mon tick
    input wire       REF_TICK_I,  // ref tick
    input wire       FB_PULSE_O,  // fb pulse
    input wire       MON_PULSE_O, // mon pulse
    input wire       REF_PULSE_O, // ref pulse
    input wire       LD_SAMPLE_O, // sample strobe
    input wire [5:0] LD_WINDOW_O, // window
    input wire       MON_PD_O     // powerdown
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    reg  [7:0] since_r;
    wire       commit = REG_WR_I && (REG_ADDR_I == 8'h01 || REG_ADDR_I == 8'h05);
    wire       hi_wr  = REG_WR_I && REG_ADDR_I == 8'h00;
    // cycles since the last reference pulse
    always @(posedge CLOCK_I or posedge RST_I)
        if (RST_I)
            since_r <= 8'h00;
        else if (REF_PULSE_O)
            since_r <= 8'h01;
        else if (since_r != 8'h00 && since_r != 8'hff)
            since_r <= since_r + 8'h01;
    a_fb_tick_cause: assert property (FB_PULSE_O |-> $past(FB_TICK_I))
        else $error("fb pulse without tick");
    a_mon_tick_cause: assert property (MON_PULSE_O |-> $past(MON_TICK_I))
        else $error("mon pulse without tick");
    a_ref_tick_cause: assert property (REF_PULSE_O |-> $past(REF_TICK_I))
        else $error("ref pulse without tick");
    a_mon_pd_quiet: assert property (MON_PD_O |-> !MON_PULSE_O)
        else $error("mon pulse while powered down");
    a_pd_bit_follows: assert property (hi_wr ##1 !hi_wr |=>
        MON_PD_O == $past(REG_WDATA_I[4], 2))
        else $error("powerdown not applied");
    a_sample_delay: assert property (LD_SAMPLE_O |->
        since_r == {5'h00, LD_WINDOW_O[5:3]} + {5'h00, LD_WINDOW_O[2:0]} + 8'h02)
        else $error("sample strobe off window");
    // window output loads its reset setting on the first edge after reset, so skip that edge
    a_window_hold: assert property (!commit && !$past(commit) && !$past(RST_I) |=>
        $stable(LD_WINDOW_O))
        else $error("window moved without commit");
    c_sample: cover property (LD_SAMPLE_O);
    c_pd_tick: cover property (MON_PD_O && MON_TICK_I);
    c_fb_pulse: cover property (FB_PULSE_O);
endmodule // vfd_top_assertions

bind vfd_top vfd_top_assertions u_chk (.CLOCK_I, .RST_I, .REG_ADDR_I, .REG_WDATA_I,
    .REG_WR_I, .FB_TICK_I, .MON_TICK_I, .REF_TICK_I, .FB_PULSE_O, .MON_PULSE_O,
    .REF_PULSE_O, .LD_SAMPLE_O, .LD_WINDOW_O, .MON_PD_O);

// [sim/vfd_top_test.sv]
`timescale 1ns/10ps
module vfd_top_test;
    reg          clk, rst, wr_s, rd_s, ft, mt, rt, clr_s, ck_s, rd_d;
    reg   [7:0]  addr, wdat;
    reg   [2:0]  ck_sel;
    reg   [16:0] lf;
    reg   [11:0] dv;
    logic [11:0] cnt [4];
    logic [11:0] eq [$];
    string       nq [$];
    int          bad_count, tests_run, cyc, i;
    wire  [7:0]  rdat;
    wire  [5:0]  win;
    wire         pd;
    wire  [3:0]  p;
    logic [7:0]  rv [7] = '{8'hac, 8'h00, 8'h1e, 8'h00, 8'hac, 8'h00, 8'h00};

    vfd_top u_vfd_top (.CLOCK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdat),
        .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdat), .FB_TICK_I(ft),
        .MON_TICK_I(mt), .REF_TICK_I(rt), .FB_PULSE_O(p[0]), .MON_PULSE_O(p[1]),
        .REF_PULSE_O(p[2]), .LD_SAMPLE_O(p[3]), .LD_WINDOW_O(win), .MON_PD_O(pd));

    function [16:0] lfsr(input [16:0] s);
        lfsr = {s[15:0], s[16] ^ s[13]};
    endfunction
    task after_edge;
        @(posedge clk) #2;
    endtask
    task final_report;
    begin
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task cmp(input [11:0] v);
    begin
        tests_run++;
        if (eq[0] !== v)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nq[0], eq[0], v);
        end
        void'(eq.pop_front());
        void'(nq.pop_front());
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        after_edge;
        {addr, wdat, wr_s} = {a, d, 1'b1};
        after_edge;
        wr_s = 0;
    end
    endtask
    task rd(input [7:0] a, input [7:0] e, input string n);
    begin
        eq.push_back({4'h0, e});
        nq.push_back(n);
        after_edge;
        {addr, rd_s} = {a, 1'b1};
        after_edge;
        rd_s = 0;
    end
    endtask
    task cc(input [2:0] s, input [11:0] e, input string n);
    begin
        eq.push_back(e);
        nq.push_back(n);
        after_edge;
        {ck_sel, ck_s} = {s, 1'b1};
        after_edge;
        ck_s = 0;
    end
    endtask
    task tk(input [2:0] t, input [11:0] n);
    begin
        after_edge;
        {ft, mt, rt, clr_s} = {t, 1'b1};
        after_edge;
        clr_s = 0;
        repeat (n - 1) @(posedge clk);
        #2 {ft, mt, rt} = 3'h0;
        repeat (12) @(posedge clk);
    end
    endtask

    // clock
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // scoreboard, pulse counters and hang ceiling
    always @(posedge clk)
    begin
        rd_d <= rd_s;
        cyc <= cyc + 1;
        if (rd_d)
            cmp({4'h0, rdat});
        if (ck_s)
            cmp(ck_sel < 4 ? cnt[ck_sel[1:0]] : ck_sel == 4 ? {6'h00, win} : {11'h000, pd});
        for (int k = 0; k < 4; k++)
            cnt[k] <= clr_s ? 12'h000 : cnt[k] + {11'h000, p[k]};
        if (cyc == 3000)
        begin
            bad_count++;
            final_report;
        end
    end
    // main sequence
    initial
    begin
        {rst, wr_s, rd_s, ft, mt, rt, clr_s, ck_s, rd_d} = 9'h100;
        {addr, wdat, ck_sel, cyc, bad_count, tests_run} = 0;
        lf = 17'h149ff;
        repeat (3) @(posedge clk);
        #2 rst = 0;
        for (i = 0; i < 7; i++)
            rd(i == 6 ? 8'h07 : i[7:0], rv[i], "reset read");
        cc(4, 12'h02d, "window");
        for (i = 0; i < 2; i++)
        begin
            lf = lfsr(lf);
            dv = i ? 12'd64 : {7'h00, lf[4:0]} + 12'd32;
            wr(8'h00, {i ? 3'h3 : 3'h2, 5'h00});
            rd(8'h00, i ? 8'h40 : 8'hac, "staged hi");
            wr(8'h01, dv[7:0]);
            rd(8'h01, dv[7:0], "main lo");
            tk(3'h4, 12'd130);
            cc(0, 12'd130 / dv, "fb pulses");
        end
        lf = lfsr(lf);
        dv = {9'h000, lf[2:0]} + 12'h004;
        wr(8'h02, dv[7:0]);
        rd(8'h02, 8'h1e, "mon staged");
        wr(8'h03, 8'h00);
        rd(8'h02, dv[7:0], "mon lo");
        tk(3'h2, 12'd40);
        cc(1, 12'd40 / dv, "mon pulses");
        wr(8'h00, 8'h50);
        cc(5, 12'h001, "powerdown");
        tk(3'h2, 12'd40);
        cc(1, 12'h000, "mon stopped");
        wr(8'h00, 8'h40);
        wr(8'h04, 8'h40);
        wr(8'h05, 8'h08);
        rd(8'h05, 8'h08, "ref lo");
        cc(4, 12'h013, "window");
        tk(3'h1, 12'd40);
        cc(2, 12'd5, "ref pulses");
        cc(3, 12'd5, "samples");
        final_report;
    end
endmodule // vfd_top_test
